// ---- csc_route_select_cfg.sv ----
// csc_route_select_cfg: per-socket card status change interrupt configuration, event flags and routing.
// assumes an apb master on pclk and socket pins arriving asynchronously from the card.
`timescale 1ns/10ps

// What this block does
// - upper nibble of config register selects where the status change interrupt goes
// - routing code zero or reserved delivers interrupt on the pci line
// - routing field resets to zero, so pci line first
// - routing field clears on card removal when removal clear is enabled
// - codes 3,4,5,7,9,10,11,12,14,15 select that isa line; others reserved
// - detect-change enable raises interrupt when either card detect pin changes
// - ready-rise enable raises interrupt on ready/busy low-to-high
// - ready and battery-warning enables set no flag in io card mode
// - battery-warning enable raises interrupt on memory card battery warning
// - battery-dead enable raises interrupt on battery dead in memory mode
// - in io mode bit 0 raises interrupt when status change pin goes low
// - bit 0 clear means no battery dead or status change interrupt
// - a flag is only set while its enable bit is one
// - a flag reads zero while its enable bit is zero
// - removal clear enable pulses a socket register reset when both detects high
module csc_route_select_cfg (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire csc_pkg::csc_pins_t socket_pins,
  output logic irq,
  output csc_pkg::csc_route_out_t route_out,
  output logic reg_reset_pulse
);

  // register state
  logic [3:0] route_r;
  logic [3:0] route_nxt;
  logic [3:0] en_r;
  logic [3:0] en_nxt;
  logic [3:0] flags_r;
  logic [3:0] flags_nxt;
  logic [3:0] mask_r;
  logic [3:0] mask_nxt;
  logic [1:0] ctrl_r;
  logic [1:0] ctrl_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic irq_r;
  logic pulse_r;
  csc_pkg::csc_route_out_t route_out_r;
  csc_pkg::csc_route_out_t route_out_nxt;

  // pin synchronisers and history
  csc_pkg::csc_pins_t sync1_r;
  csc_pkg::csc_pins_t sync2_r;
  csc_pkg::csc_pins_t prev_r;

  // bus decode
  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  wire wr_access = access_phase & pwrite;
  wire hit_cfg = (paddr == csc_pkg::CSC_OFF_CFG);
  wire hit_stat = (paddr == csc_pkg::CSC_OFF_STAT);
  wire hit_mask = (paddr == csc_pkg::CSC_OFF_MASK);
  wire hit_ctrl = (paddr == csc_pkg::CSC_OFF_CTRL);
  wire hit_pins = (paddr == csc_pkg::CSC_OFF_PINS);
  wire hit_any = hit_cfg | hit_stat | hit_mask | hit_ctrl | hit_pins;
  wire wr_cfg = wr_access & hit_cfg;
  wire wr_stat = wr_access & hit_stat;
  wire wr_mask = wr_access & hit_mask;
  wire wr_ctrl = wr_access & hit_ctrl;

  // mode and control
  wire io_mode = ctrl_r[csc_pkg::CSC_CTRL_IO_MODE];
  wire removal_reg_clear_en = ctrl_r[csc_pkg::CSC_CTRL_REMOVAL_CLR];

  // named enables
  wire detect_change_irq_en = en_r[csc_pkg::CSC_BIT_DETECT];
  wire ready_rise_irq_en = en_r[csc_pkg::CSC_BIT_READY];
  wire batt_warn_irq_en = en_r[csc_pkg::CSC_BIT_WARN];
  wire batt_dead_irq_en = en_r[csc_pkg::CSC_BIT_DEAD];
  // same bit, read as the status change pin enable in io mode
  wire status_change_pin_irq_en = en_r[csc_pkg::CSC_BIT_DEAD];

  // event detection on synchronised pins only
  wire detect_change = (sync2_r.card_detect_1_n != prev_r.card_detect_1_n) |
                       (sync2_r.card_detect_2_n != prev_r.card_detect_2_n);
  wire ready_rise = sync2_r.card_ready_busy_n & ~prev_r.card_ready_busy_n;
  // memory card battery: bvd1 low is dead, bvd1 high with bvd2 low is warning
  wire dead_now = ~sync2_r.batt_volt_status_change_n;
  wire dead_was = ~prev_r.batt_volt_status_change_n;
  wire warn_now = sync2_r.batt_volt_status_change_n & ~sync2_r.batt_volt_2_n;
  wire warn_was = prev_r.batt_volt_status_change_n & ~prev_r.batt_volt_2_n;
  // in io mode the same pin is the card's status change request, active on its falling edge
  wire bit0_event = dead_now & ~dead_was;
  wire warn_event = warn_now & ~warn_was;

  wire set_detect = detect_change_irq_en & detect_change;
  wire set_ready = ready_rise_irq_en & ~io_mode & ready_rise;
  wire set_warn = batt_warn_irq_en & ~io_mode & warn_event;
  // bit 0 enable gates both meanings of the pin event
  wire set_dead = io_mode ? (status_change_pin_irq_en & bit0_event)
                          : (batt_dead_irq_en & bit0_event);
  wire [3:0] set_vec = {set_detect, set_ready, set_warn, set_dead};

  // card removal: both detect pins high, caught on the edge so the pulse is one cycle
  wire removed_now = sync2_r.card_detect_1_n & sync2_r.card_detect_2_n;
  wire removed_was = prev_r.card_detect_1_n & prev_r.card_detect_2_n;
  wire removal_clear = removal_reg_clear_en & removed_now & ~removed_was;

  // flags visible to software and to the interrupt only where enabled
  wire [3:0] flags_seen = flags_r & en_r;
  wire irq_pending = |(flags_seen & mask_r);

  // routing decode
  wire route_valid = csc_pkg::CSC_ROUTE_VALID[route_r];

  // next-state logic
  // a removal pulse in the same cycle as a config write wins for the routing field
  wire [3:0] route_wr_val = pwdata[csc_pkg::CSC_ROUTE_LSB +: csc_pkg::CSC_ROUTE_W];
  wire [3:0] en_wr_val = pwdata[csc_pkg::CSC_EN_W-1:0];
  assign route_nxt = removal_clear ? csc_pkg::CSC_ROUTE_RST :
                     wr_cfg ? route_wr_val : route_r;
  assign en_nxt = wr_cfg ? en_wr_val : en_r;
  assign mask_nxt = wr_mask ? pwdata[csc_pkg::CSC_EN_W-1:0] : mask_r;
  assign ctrl_nxt = wr_ctrl ? pwdata[csc_pkg::CSC_CTRL_W-1:0] : ctrl_r;
  // write-one-to-clear; a new event in the same cycle keeps its flag
  wire [3:0] flags_clear = wr_stat ? pwdata[csc_pkg::CSC_EN_W-1:0] : 4'h0;
  wire [3:0] flags_upd;
  generate
    for (genvar b = 0; b < csc_pkg::CSC_EN_W; b++) begin : g_flag
      // the set term is ored last so software never loses an event it has not seen
      assign flags_upd[b] = (flags_r[b] & ~flags_clear[b]) | set_vec[b];
    end
  endgenerate
  assign flags_nxt = flags_upd;

  // read words, one per register; unused upper bits read zero
  wire [31:0] rd_cfg_word = {24'h000000, route_r, en_r};
  wire [31:0] rd_stat_word = {28'h0000000, flags_seen};
  wire [31:0] rd_mask_word = {28'h0000000, mask_r};
  wire [31:0] rd_ctrl_word = {30'h0, ctrl_r};
  wire [31:0] rd_pins_word = {27'h0000000, sync2_r};

  // read data is prepared in the setup cycle so it stands in a flop during access;
  // holding it between reads keeps prdata quiet while the bus is idle
  assign prdata_nxt = ~setup_phase ? prdata_r :
                      hit_cfg ? rd_cfg_word :
                      hit_stat ? rd_stat_word :
                      hit_mask ? rd_mask_word :
                      hit_ctrl ? rd_ctrl_word :
                      hit_pins ? rd_pins_word : csc_pkg::CSC_RDATA_RST;

  // one level per destination; the line stays up for the whole service, so later
  // events during service never make a fresh edge
  wire [csc_pkg::CSC_ISA_LINES-1:0] isa_sel;
  generate
    for (genvar i = 0; i < csc_pkg::CSC_ISA_LINES; i++) begin : g_isa
      assign isa_sel[i] = irq_pending & route_valid & (route_r == 4'(i));
    end
  endgenerate
  // a reserved code falls back to the pci line rather than lighting nothing
  wire pci_sel = irq_pending & ~route_valid;
  assign route_out_nxt = '{pci_int: pci_sel, isa_irq: isa_sel};

  // irq and route_out are registered from the same term so they move on one edge
  wire irq_nxt = irq_pending;
  wire pulse_nxt = removal_clear;

  // apb answer: zero wait states, error on unmapped addresses
  assign pready = 1'b1;
  assign pslverr = access_phase & ~hit_any;
  assign prdata = prdata_r;
  assign irq = irq_r;
  assign route_out = route_out_r;
  assign reg_reset_pulse = pulse_r;

  // first synchroniser stage; nothing but the second stage reads it, so a
  // metastable value never reaches the event logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= csc_pkg::CSC_PINS_IDLE;
    end else begin
      sync1_r <= socket_pins;
    end
  end

  // second synchroniser stage, the first one the logic may read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync2_r <= csc_pkg::CSC_PINS_IDLE;
    end else begin
      sync2_r <= sync1_r;
    end
  end

  // history for edge detection; reset to the empty-socket level so that
  // leaving reset with no card never looks like a removal or a change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= csc_pkg::CSC_PINS_IDLE;
    end else begin
      prev_r <= sync2_r;
    end
  end

  // routing field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_r <= csc_pkg::CSC_ROUTE_RST;
    end else begin
      route_r <= route_nxt;
    end
  end

  // event enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= csc_pkg::CSC_EN_RST;
    end else begin
      en_r <= en_nxt;
    end
  end

  // sticky event flags; disabling an enable only hides a flag, it does not clear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= csc_pkg::CSC_FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // interrupt mask; all pass after reset so enabling an event is enough
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= csc_pkg::CSC_MASK_RST;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // card mode and removal clear enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= csc_pkg::CSC_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= csc_pkg::CSC_RDATA_RST;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // interrupt level; one cycle behind the flags, a trade for a glitch-free pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // socket register reset pulse, one cycle per removal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= pulse_nxt;
    end
  end

  // routed interrupt lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_out_r <= '0;
    end else begin
      route_out_r <= route_out_nxt;
    end
  end

endmodule : csc_route_select_cfg

// ---- csc_pkg.sv ----
// csc_pkg: constants and carrier types for the card status change interrupt block.
// assumes a 32-bit apb slave, one clock pclk, and a single 16-bit card socket.
package csc_pkg;

  // register byte offsets
  localparam logic [7:0] CSC_OFF_CFG = 8'h00;
  localparam logic [7:0] CSC_OFF_STAT = 8'h04;
  localparam logic [7:0] CSC_OFF_MASK = 8'h08;
  localparam logic [7:0] CSC_OFF_CTRL = 8'h0c;
  localparam logic [7:0] CSC_OFF_PINS = 8'h10;

  // configuration register layout
  localparam int CSC_ROUTE_LSB = 4;
  localparam int CSC_ROUTE_W = 4;
  localparam int CSC_EN_W = 4;
  localparam logic [3:0] CSC_ROUTE_RST = 4'h0;
  localparam logic [3:0] CSC_EN_RST = 4'h0;
  localparam logic [3:0] CSC_MASK_RST = 4'hf;
  localparam logic [3:0] CSC_FLAGS_RST = 4'h0;
  localparam logic [1:0] CSC_CTRL_RST = 2'h0;
  localparam logic [31:0] CSC_RDATA_RST = 32'h00000000;

  // event bit positions, shared by enables, flags and mask
  localparam int CSC_BIT_DETECT = 3;
  localparam int CSC_BIT_READY = 2;
  localparam int CSC_BIT_WARN = 1;
  localparam int CSC_BIT_DEAD = 0;

  // control register bits
  localparam int CSC_CTRL_IO_MODE = 0;
  localparam int CSC_CTRL_REMOVAL_CLR = 1;
  localparam int CSC_CTRL_W = 2;

  // routing codes that select an isa line; every other nonzero code is reserved
  localparam logic [15:0] CSC_ROUTE_VALID = 16'hdeb8;
  localparam int CSC_ISA_LINES = 16;

  // socket pins, all active low as seen on the connector
  typedef struct packed {
    logic card_detect_1_n;
    logic card_detect_2_n;
    logic card_ready_busy_n;
    logic batt_volt_status_change_n;
    logic batt_volt_2_n;
  } csc_pins_t;

  localparam csc_pins_t CSC_PINS_IDLE = '{default: 1'b1};

  // routed interrupt outputs
  typedef struct packed {
    logic pci_int;
    logic [15:0] isa_irq;
  } csc_route_out_t;

endpackage : csc_pkg

// ---- csc_route_select_cfg_monitor.sv ----
// csc_route_select_cfg_monitor: port-level assertions for the status change interrupt block.
// assumes it is bound to csc_route_select_cfg and sees only that module's ports.
`timescale 1ns/10ps
module csc_route_select_cfg_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire csc_pkg::csc_pins_t socket_pins,
  input wire logic irq,
  input wire csc_pkg::csc_route_out_t route_out,
  input wire logic reg_reset_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc_wr = psel && penable && pwrite;
  chk_route_level: assert property ((|route_out) == irq)
    else $error("routed outputs disagree with irq");
  chk_route_legal: assert property ($onehot0(route_out) && !(route_out.isa_irq & ~csc_pkg::CSC_ROUTE_VALID))
    else $error("illegal routed line active");
  chk_pulse_single: assert property (reg_reset_pulse |=> !reg_reset_pulse)
    else $error("reset pulse longer than one cycle");
  chk_pulse_cause: assert property ($rose(reg_reset_pulse)
    |-> $past(socket_pins.card_detect_1_n, 3) && $past(socket_pins.card_detect_2_n, 3))
    else $error("reset pulse without card removal");
  chk_route_cleared: assert property ($rose(reg_reset_pulse) |=> route_out.isa_irq == 16'h0)
    else $error("isa line still selected after removal");
  chk_mask_quiet: assert property (acc_wr && paddr == csc_pkg::CSC_OFF_MASK && pwdata[3:0] == 4'h0
    |=> ##1 !irq)
    else $error("irq stays with all masked");
  chk_enable_quiet: assert property (acc_wr && paddr == csc_pkg::CSC_OFF_CFG && pwdata[3:0] == 4'h0
    |=> ##1 !irq)
    else $error("irq stays with enables cleared");
  chk_unmapped_err: assert property (psel && penable && paddr > 8'h10 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  // the main scenarios, so a silent bench shows up as uncovered
  cov_irq: cover property ($rose(irq));
  cov_pulse: cover property (reg_reset_pulse);
  cov_err: cover property (pslverr);
  cov_isa: cover property (|route_out.isa_irq);
endmodule : csc_route_select_cfg_monitor

bind csc_route_select_cfg csc_route_select_cfg_monitor u_csc_route_select_cfg_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .socket_pins(socket_pins), .irq(irq), .route_out(route_out), .reg_reset_pulse(reg_reset_pulse));

// ---- csc_card_model.sv ----
// csc_card_model: the 16-bit card in the socket, as levels on its status pins.
// assumes the bench commands each pin change; pins stand still between commands.
`timescale 1ns/10ps
module csc_card_model (
  input wire logic pclk,
  output csc_pkg::csc_pins_t socket_pins
);
  // socket empty at start, so the first insertion is a real detect change
  initial socket_pins = csc_pkg::CSC_PINS_IDLE;
  task put(input csc_pkg::csc_pins_t v);
    @(posedge pclk);
    socket_pins <= v;
  endtask : put
endmodule : csc_card_model

// ---- tb_csc_route_select_cfg.sv ----
// tb_csc_route_select_cfg: self-checking bench for the status change interrupt block.
// assumes zero-wait apb and the card model driving the socket pins.
`timescale 1ns/10ps
module tb_csc_route_select_cfg;
  localparam logic [7:0] CFG = csc_pkg::CSC_OFF_CFG;
  localparam logic [7:0] STA = csc_pkg::CSC_OFF_STAT;
  localparam logic [7:0] MSK = csc_pkg::CSC_OFF_MASK;
  localparam logic [7:0] CTL = csc_pkg::CSC_OFF_CTRL;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, reg_reset_pulse, le;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  csc_pkg::csc_pins_t socket_pins, pv;
  csc_pkg::csc_route_out_t route_out;
  int n_fail = 0, checked = 0, npulse = 0;
  csc_route_select_cfg u_csc_route_select_cfg (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .socket_pins(socket_pins), .irq(irq), .route_out(route_out), .reg_reset_pulse(reg_reset_pulse));
  csc_card_model u_csc_card_model (.pclk(pclk), .socket_pins(socket_pins));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) if (reg_reset_pulse === 1'b1) npulse <= npulse + 1;
  task cmp(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : cmp
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata; le = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e); xfer(1'b0, a, 32'h0); cmp(rv, e); endtask : rd
  task settle; repeat (6) @(posedge pclk); endtask : settle
  // old flags are cleared after the base pins settle, so only the a-to-b edge counts
  task ev(input csc_pkg::csc_pins_t a, b, input logic [7:0] cfg, input logic [1:0] ctl, input logic [3:0] st);
    u_csc_card_model.put(a); settle; wr(STA, 32'hf); wr(CTL, ctl); wr(CFG, cfg);
    u_csc_card_model.put(b); settle; rd(STA, st); cmp(irq, st != 4'h0);
  endtask : ev
  task print_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    print_verdict;
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(CFG, 32'h0);
    cmp(pready, 1'b1);
    rd(STA, 32'h0); rd(MSK, 32'hf); rd(CTL, 32'h0);
    rd(csc_pkg::CSC_OFF_PINS, 32'h1f);
    rd(8'h14, 32'h0); cmp(le, 1'b1);
    wr(CFG, 32'hfff); rd(CFG, 32'hff);
    ev(5'h03, 5'h07, 8'h00, 2'h0, 4'h0);
    wr(CFG, 32'h04); rd(STA, 32'h0);
    ev(5'h03, 5'h07, 8'h04, 2'h0, 4'h4);
    ev(5'h03, 5'h07, 8'h04, 2'h1, 4'h0);
    ev(5'h07, 5'h06, 8'h02, 2'h1, 4'h0);
    ev(5'h07, 5'h06, 8'h02, 2'h0, 4'h2);
    ev(5'h07, 5'h05, 8'h01, 2'h0, 4'h1);
    ev(5'h07, 5'h05, 8'h01, 2'h1, 4'h1);
    ev(5'h07, 5'h05, 8'h0e, 2'h1, 4'h0);
    ev(5'h07, 5'h05, 8'h0e, 2'h0, 4'h0);
    ev(5'h07, 5'h17, 8'h08, 2'h0, 4'h8);
    wr(MSK, 32'h0); settle; cmp(irq, 1'b0);
    wr(MSK, 32'hf); settle; cmp(irq, 1'b1);
    u_csc_card_model.put(5'h07); settle; cmp(irq, 1'b1);
    wr(STA, 32'h8); settle; cmp(irq, 1'b0);
    wr(CTL, 32'h0);
    pv = 5'h07;
    for (int c = 0; c < 16; c++) begin
      wr(STA, 32'hf); wr(CFG, {c[3:0], 4'h8});
      pv.card_detect_1_n = ~pv.card_detect_1_n;
      u_csc_card_model.put(pv); settle;
      cmp(route_out, {!csc_pkg::CSC_ROUTE_VALID[c], csc_pkg::CSC_ROUTE_VALID[c] ? 16'h1 << c : 16'h0});
    end
    wr(STA, 32'hf); wr(CTL, 32'h2); wr(CFG, 32'h58);
    npulse = 0;
    u_csc_card_model.put(5'h1f); settle;
    cmp(npulse, 1);
    rd(CFG, 32'h08);
    print_verdict;
  end
endmodule : tb_csc_route_select_cfg
